//--- hfc_bus_cycle.sv
// Purpose: Runs one asynchronous flash read or write cycle on the pins
// Assumes: dqSync is already synchronised to sys_clk
// Notes: Fixed setup, strobe and hold phases; one cycle at a time
module hfc_bus_cycle
  import hfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic byteMode,
  input wire logic start,
  input hfc_cyc_t cyc,
  input wire logic [15:0] dqSync,
  output hfc_pins_t pins,
  output logic [15:0] rdata,
  output logic done
);
`include "hfc_defs.svh"

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} hfc_cst_t;

  // Whole state of the cycle engine
  typedef struct packed {
    hfc_cst_t st;
    logic [3:0] cnt;
    logic isWrite;
    hfc_pins_t pins;
    logic [15:0] rdata;
    logic done;
  } hfc_cstate_t;

  hfc_cstate_t s_reg;
  hfc_cstate_t s_next;

  // Pins idle: deselected, strobes high, bus released
  function automatic hfc_pins_t idlePins();
    hfc_pins_t p;
    p = '0;
    p.ceN = 1'b1;
    p.oeN = 1'b1;
    p.weN = 1'b1;
    return p;
  endfunction : idlePins

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      C_IDLE: begin
        if (start) begin
          // Address and chip select settle before the strobe
          s_next.st = C_SETUP;
          s_next.isWrite = cyc.isWrite;
          s_next.pins = idlePins();
          s_next.pins.ceN = 1'b0;
          if (byteMode) begin
            // Byte lane bit rides on DQ15
            s_next.pins.addr = cyc.addr[24:1];
            s_next.pins.dqOut = {cyc.addr[0], 7'h00, cyc.data[7:0]};
            s_next.pins.dqOe = cyc.isWrite ? 16'h80FF : 16'h8000;
          end else begin
            s_next.pins.addr = cyc.addr[23:0];
            s_next.pins.dqOut = cyc.data;
            s_next.pins.dqOe = cyc.isWrite ? 16'hFFFF : 16'h0000;
          end
        end
      end
      C_SETUP: begin
        // Reads wait out the synchroniser on top of access time
        s_next.st = C_PULSE;
        s_next.cnt = s_reg.isWrite ? 4'(`HFC_PULSE_CYC - 1) :
          4'(`HFC_PULSE_CYC + `HFC_SYNC_LAT - 1);
        s_next.pins.weN = ~s_reg.isWrite;
        s_next.pins.oeN = s_reg.isWrite;
      end
      C_PULSE: begin
        if (s_reg.cnt == 4'h0) begin
          // Rising strobe latches the write; read data captured here
          s_next.st = C_HOLD;
          s_next.pins.weN = 1'b1;
          s_next.pins.oeN = 1'b1;
          if (!s_reg.isWrite) begin
            s_next.rdata = byteMode ? {8'h00, dqSync[7:0]} : dqSync;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      default: begin
        // Hold: release bus and deselect
        s_next.st = C_IDLE;
        s_next.pins = idlePins();
        s_next.done = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: C_IDLE, cnt: 4'h0, isWrite: 1'b0,
        pins: '{addr: 24'h000000, dqOut: 16'h0000, dqOe: 16'h0000,
        ceN: 1'b1, oeN: 1'b1, weN: 1'b1}, rdata: 16'h0000, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins = s_reg.pins;
  assign rdata = s_reg.rdata;
  assign done = s_reg.done;

endmodule : hfc_bus_cycle

//--- hfc_defs.svh
// Purpose: Constants for the host side of a flash secure/query controller
// Assumes: 40 MHz sys_clk, parallel NOR flash with byte/word bus
// Notes: Every address here is a word address unless named otherwise
`ifndef HFC_DEFS_SVH
`define HFC_DEFS_SVH

// Clock rate used to turn times into cycle counts
`define HFC_CLK_MHZ 40
// Write or read strobe width, least time
`define HFC_T_PULSE_NS 100
`define HFC_PULSE_CYC ((`HFC_T_PULSE_NS * `HFC_CLK_MHZ + 999) / 1000)
// Hardware reset low time, least time
`define HFC_T_RP_NS 500
`define HFC_RP_CYC ((`HFC_T_RP_NS * `HFC_CLK_MHZ + 999) / 1000)
// Extra read cycles spent in the pin synchroniser
`define HFC_SYNC_LAT 2

// Unlock pair written ahead of the secure-region sequences
`define HFC_UNLOCK1_ADR 24'h000555
`define HFC_UNLOCK2_ADR 24'h0002AA
`define HFC_UNLOCK1_DAT 16'h00AA
`define HFC_UNLOCK2_DAT 16'h0055
`define HFC_SEC_ENTER_DAT 16'h0088
`define HFC_SEC_EXIT_DAT 16'h0090
`define HFC_SEC_EXIT2_DAT 16'h0000
// Reset command, also leaves query mode
`define HFC_RESET_DAT 16'h00F0
// Query entry command and its word address
`define HFC_QRY_DAT 16'h0098
`define HFC_QRY_ADR 24'h000055
// Word-mode query reads keep only these address bits
`define HFC_QRY_WORD_MASK 25'h000007F
// Query signature location and expected words
`define HFC_SIG_ADR 24'h000010
`define HFC_SIG0 16'h0051
`define HFC_SIG1 16'h0052
`define HFC_SIG2 16'h0059

`endif

//--- hfc_flash_model.sv
// Purpose: Behavioural flash device facing the host controller
// Assumes: Word address on pins.addr; A-1 rides on DQ15 in byte mode
// Notes: Answers after ACC_NS; unwritten array words follow a pattern
module hfc_flash_model
  import hfc_pkg::*;
#(
  parameter int ACC_NS = 60, // Slow enough to test the sample point
  parameter logic [15:0] ID_WORD = 16'h1D2E // Arbitrary value
) (
  input wire logic byteMode,
  input hfc_pins_t pins,
  input wire logic flashResetN,
  input wire logic [15:0] dqBus,
  output wire logic [15:0] dqDrive
);
  timeunit 1ns;
  timeprecision 1ps;

  // Query table bytes for words 10h..3Ch
  localparam logic [359:0] QRY_TBL = {128'h51525902004000000000002736000003,
    136'h04090005050400190200060001FF000002, 96'h0};
  localparam logic [23:0] SECTOR_WORDS = 24'h010000; // Lowest sector
  logic secureMode = 1'h0; // Secure region overlays lowest sector
  logic queryMode = 1'h0; // Table mode
  logic autoMode = 1'h0; // Identification mode
  logic exitPend = 1'h0; // Exit sequence half done
  logic progPend = 1'h0; // Next write programs a word
  int step = 0; // Unlock progress
  logic [15:0] arrMem [int]; // Programmed array words
  logic [15:0] secMem [int]; // Programmed customer secure words
  logic [15:0] word, lane, lastVal;
  wire logic rdEn = !pins.ceN && !pins.oeN && flashResetN;
  wire logic [23:0] wa = pins.addr;
  wire logic [7:0] cmd = dqBus[7:0];
  wire logic accelAllowed = !secureMode;

  // Word seen at the pins in the present mode
  function automatic logic [15:0] rd_val(input logic [23:0] a);
    int idx;
    if (queryMode) begin
      if (!byteMode && a[23:7] != 17'h0) return 16'hBAD0;
      if (a < 24'h10 || a > 24'h3C) return 16'h0000;
      idx = 359 - 8 * (int'(a) - 16);
      return {8'h00, QRY_TBL[idx -: 8]};
    end
    if (autoMode) return ID_WORD;
    if (secureMode && a < SECTOR_WORDS) begin
      if (a >= 24'h80) return ~a[15:0];
      return secMem.exists(a) ? secMem[a] : {8'h5E, a[7:0]};
    end
    return arrMem.exists(a) ? arrMem[a] : a[15:0] ^ 16'hA5C3;
  endfunction : rd_val

  // Command decode on the write strobe's rising edge
  always @(posedge pins.weN or negedge flashResetN) begin
    if (!flashResetN) begin
      secureMode = 1'h0;
      queryMode = 1'h0;
      autoMode = 1'h0;
      exitPend = 1'h0;
      progPend = 1'h0;
      step = 0;
    end else if (!pins.ceN) begin
      if (progPend) begin
        if (secureMode && wa < SECTOR_WORDS) begin
          if (wa >= 24'h8 && wa < 24'h80) secMem[wa] = dqBus;
        end else
          arrMem[wa] = dqBus;
        progPend = 1'h0;
      end else if (cmd == 8'hF0) begin
        if (queryMode) queryMode = 1'h0;
        else autoMode = 1'h0;
        step = 0;
      end else if (cmd == 8'h98 && wa == 24'h55 && !queryMode) begin
        queryMode = 1'h1;
      end else if (step == 0 && wa == 24'h555 && cmd == 8'hAA) begin
        step = 1;
      end else if (step == 1 && wa == 24'h2AA && cmd == 8'h55) begin
        step = 2;
      end else if (step == 2 && wa == 24'h555) begin
        step = 0;
        if (cmd == 8'h88) secureMode = 1'h1;
        else if (cmd == 8'h90 && secureMode) exitPend = 1'h1;
        else if (cmd == 8'h90) autoMode = 1'h1;
        else if (cmd == 8'hA0) progPend = 1'h1;
      end else if (exitPend && cmd == 8'h00) begin
        secureMode = 1'h0;
        exitPend = 1'h0;
      end else
        step = 0;
    end
  end

  // Output lane, and what is left once released
  always @(pins or dqBus[15] or byteMode or queryMode or autoMode
           or secureMode or flashResetN or rdEn) begin
    word = rd_val(wa);
    lane = (byteMode && dqBus[15]) ? {word[7:0], word[15:8]} : word;
    if (rdEn)
      lastVal = lane;
  end
  // A released bus shows the inverse, never a stale copy
  assign #(ACC_NS) dqDrive = rdEn ? lane : ~lastVal;
endmodule : hfc_flash_model

//--- hfc_host.sv
// Purpose: Host controller that steers a flash into secure/query modes
// Assumes: One request at a time; flash data pins arrive unsynchronised
// Notes: Tracks the device mode it has commanded; does not hold the table
// Functional notes
// - Secure entry is three write cycles
// - Query entry writes 98h to 55h/AAh
// - Word-mode query reads zero A7 and up
// - Reset command leaves query, restores prior mode
module hfc_host
  import hfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic byteMode,
  input wire logic reqValid,
  output logic reqReady,
  input hfc_req_t req,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspErr,
  output logic rspMatch,
  output logic secureActive,
  output logic queryActive,
  output hfc_pins_t pins,
  output logic flashResetN,
  input wire logic [15:0] dqIn
);
`include "hfc_defs.svh"

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT, S_RST} hfc_st_t;

  // Whole state of the sequencer
  typedef struct packed {
    hfc_st_t st;
    hfc_req_t cur;
    logic [1:0] idx;
    logic [4:0] cnt;
    logic secure;
    logic query;
    logic match;
    logic rspValid;
    logic [15:0] rspData;
    logic rspErr;
    logic resetN;
    logic [15:0] dqMeta;
    logic [15:0] dqSync;
  } hfc_state_t;

  hfc_state_t s_reg;
  hfc_state_t s_next;
  logic cycStart;
  hfc_cyc_t cyc;
  logic [15:0] cycRdata;
  logic cycDone;

  // Word address to device address; byte mode doubles it
  function automatic logic [24:0] devAddr(logic [23:0] w, logic bm);
    return bm ? {w, 1'b0} : {1'b0, w};
  endfunction : devAddr

  // Index of the final bus cycle of each operation
  function automatic logic [1:0] lastIdx(hfc_op_t op);
    case (op)
      OP_SEC_ENTER: return 2'd2;
      OP_SEC_EXIT: return 2'd3;
      OP_PROBE: return 2'd2;
      default: return 2'd0;
    endcase
  endfunction : lastIdx

  // Expected signature word for probe step i
  function automatic logic [15:0] sigWord(logic [1:0] i);
    case (i)
      2'd0: return `HFC_SIG0;
      2'd1: return `HFC_SIG1;
      default: return `HFC_SIG2;
    endcase
  endfunction : sigWord

  // Bus cycle for step i of the current operation
  function automatic hfc_cyc_t stepCycle(hfc_req_t r, logic [1:0] i,
      logic bm, logic qry);
    hfc_cyc_t c;
    c = '{isWrite: 1'b1, addr: devAddr(`HFC_UNLOCK1_ADR, bm),
      data: `HFC_UNLOCK1_DAT};
    case (r.op)
      OP_SEC_ENTER, OP_SEC_EXIT: begin
        // Unlock pair, command, and for exit a trailing cycle
        if (i == 2'd1) begin
          c.addr = devAddr(`HFC_UNLOCK2_ADR, bm);
          c.data = `HFC_UNLOCK2_DAT;
        end else if (i == 2'd2) begin
          c.data = (r.op == OP_SEC_ENTER) ? `HFC_SEC_ENTER_DAT :
            `HFC_SEC_EXIT_DAT;
        end else if (i == 2'd3) begin
          c.addr = 25'h0000000;
          c.data = `HFC_SEC_EXIT2_DAT;
        end
      end
      OP_QRY_ENTER: begin
        c.addr = devAddr(`HFC_QRY_ADR, bm);
        c.data = `HFC_QRY_DAT;
      end
      OP_QRY_EXIT: begin
        c.addr = 25'h0000000;
        c.data = `HFC_RESET_DAT;
      end
      OP_PROBE: begin
        c.isWrite = 1'b0;
        c.addr = devAddr(`HFC_SIG_ADR + 24'(i), bm);
      end
      OP_WRITE: begin
        c.addr = r.addr;
        c.data = r.data;
      end
      default: begin
        // Plain read; query reads in word mode clear A7 and up
        c.isWrite = 1'b0;
        c.addr = (qry && !bm) ? (r.addr & `HFC_QRY_WORD_MASK) : r.addr;
      end
    endcase
    return c;
  endfunction : stepCycle

  // Sequencer next state
  always_comb begin
    s_next = s_reg;
    s_next.rspValid = 1'b0;
    s_next.dqMeta = dqIn;
    s_next.dqSync = s_reg.dqMeta;
    case (s_reg.st)
      S_IDLE: begin
        if (reqValid) begin
          s_next.cur = req;
          s_next.idx = 2'd0;
          s_next.match = 1'b1;
          if (req.op == OP_HW_RESET) begin
            s_next.st = S_RST;
            s_next.cnt = 5'(`HFC_RP_CYC - 1);
            s_next.resetN = 1'b0;
          end else if ((req.op == OP_QRY_ENTER && s_reg.query) ||
              (req.op == OP_SEC_ENTER && (s_reg.secure || s_reg.query)) ||
              (req.op == OP_SEC_EXIT && (!s_reg.secure || s_reg.query)) ||
              (req.op == OP_QRY_EXIT && !s_reg.query)) begin
            // Refused: would not match the commanded device mode
            s_next.rspValid = 1'b1;
            s_next.rspErr = 1'b1;
          end else begin
            s_next.st = S_RUN;
          end
        end
      end
      S_RUN: begin
        // One cycle to launch the bus cycle
        s_next.st = S_WAIT;
      end
      S_WAIT: begin
        if (cycDone) begin
          if (s_reg.cur.op == OP_PROBE &&
              cycRdata != sigWord(s_reg.idx)) begin
            s_next.match = 1'b0;
          end
          if (s_reg.idx == lastIdx(s_reg.cur.op)) begin
            s_next.st = S_IDLE;
            s_next.rspValid = 1'b1;
            s_next.rspErr = 1'b0;
            s_next.rspData = cycRdata;
            case (s_reg.cur.op)
              OP_SEC_ENTER: s_next.secure = 1'b1;
              OP_SEC_EXIT: s_next.secure = 1'b0;
              OP_QRY_ENTER: s_next.query = 1'b1;
              OP_QRY_EXIT: s_next.query = 1'b0;
              default: s_next.query = s_reg.query;
            endcase
          end else begin
            s_next.idx = s_reg.idx + 2'd1;
            s_next.st = S_RUN;
          end
        end
      end
      default: begin
        // Hardware reset pulse returns the flash to array reads
        s_next.secure = 1'b0;
        s_next.query = 1'b0;
        if (s_reg.cnt == 5'h00) begin
          s_next.st = S_IDLE;
          s_next.resetN = 1'b1;
          s_next.rspValid = 1'b1;
          s_next.rspErr = 1'b0;
        end else begin
          s_next.cnt = s_reg.cnt - 5'h01;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: S_IDLE, cur: '{op: OP_READ, addr: 25'h0000000,
        data: 16'h0000}, idx: 2'd0, cnt: 5'h00, secure: 1'b0,
        query: 1'b0, match: 1'b0, rspValid: 1'b0, rspData: 16'h0000,
        rspErr: 1'b0, resetN: 1'b1, dqMeta: 16'h0000, dqSync: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cycStart = (s_reg.st == S_RUN);
  assign cyc = stepCycle(s_reg.cur, s_reg.idx, byteMode, s_reg.query);

  // One flash bus cycle at a time
  hfc_bus_cycle hfc_bus_cycle_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .byteMode(byteMode),
    .start(cycStart),
    .cyc(cyc),
    .dqSync(s_reg.dqSync),
    .pins(pins),
    .rdata(cycRdata),
    .done(cycDone)
  );

  assign reqReady = (s_reg.st == S_IDLE);
  assign rspValid = s_reg.rspValid;
  assign rspData = s_reg.rspData;
  assign rspErr = s_reg.rspErr;
  assign rspMatch = s_reg.match;
  assign secureActive = s_reg.secure;
  assign queryActive = s_reg.query;
  assign flashResetN = s_reg.resetN;

  // Secure access only after the third write cycle
  property p_sec_enter;
    @(posedge sys_clk) disable iff (rst)
      $rose(s_reg.secure) |-> $past(s_reg.idx) == 2'd2 &&
        $past(s_reg.cur.op) == OP_SEC_ENTER;
  endproperty
  a_sec_enter: assert property (p_sec_enter)
    else $error("secure entry without three cycles");

  // Secure access ends only by four-cycle exit or hardware reset
  property p_sec_exit;
    @(posedge sys_clk) disable iff (rst)
      $fell(s_reg.secure) |-> ($past(s_reg.idx) == 2'd3 &&
        $past(s_reg.cur.op) == OP_SEC_EXIT) || $past(s_reg.st) == S_RST;
  endproperty
  a_sec_exit: assert property (p_sec_exit)
    else $error("secure access left without exit sequence");

  // Query entry cycle carries the query command at its address
  property p_qry_cmd;
    @(posedge sys_clk) disable iff (rst)
      cycStart && s_reg.cur.op == OP_QRY_ENTER |=> ##1
        pins.dqOut[7:0] == 8'(`HFC_QRY_DAT) &&
        pins.addr == `HFC_QRY_ADR && !pins.ceN;
  endproperty
  a_qry_cmd: assert property (p_qry_cmd)
    else $error("query entry cycle wrong");

  // Word-mode query reads put zero on A7 and above
  property p_qry_addr;
    @(posedge sys_clk) disable iff (rst)
      cycStart && !cyc.isWrite && s_reg.query && !byteMode |=>
        ##1 pins.addr[23:7] == 17'h00000;
  endproperty
  a_qry_addr: assert property (p_qry_addr)
    else $error("query read address above A6 not zero");

  // Leaving query keeps the secure state unchanged
  property p_qry_exit;
    @(posedge sys_clk) disable iff (rst)
      $fell(s_reg.query) && $past(s_reg.st) != S_RST |->
        s_reg.secure == $past(s_reg.secure);
  endproperty
  a_qry_exit: assert property (p_qry_exit)
    else $error("query exit disturbed prior mode");

  // Reset pin held low, then secure access gone
  property p_hw_reset;
    @(posedge sys_clk) disable iff (rst)
      $fell(s_reg.resetN) |-> !s_reg.resetN [*8] ##1 !s_reg.secure;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("hardware reset too short or secure kept");

  c_secure: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(s_reg.secure));
  c_query: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(s_reg.query));
  c_probe: cover property (@(posedge sys_clk) disable iff (rst)
    s_reg.rspValid && s_reg.cur.op == OP_PROBE && s_reg.match);

endmodule : hfc_host

//--- hfc_host_test.sv
// Purpose: Self-checking bench for the host flash secure/query controller
// Assumes: hfc_flash_model stands in for the flash
// Notes: Scripted rows first, then table, byte mode and hardware reset
`include "hfc_defs.svh"
module hfc_host_test
  import hfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // One scripted request and what it should give
  typedef struct packed {
    hfc_op_t op;
    logic [24:0] addr;
    logic [15:0] data;
    logic [3:0] flags; // Refused, secure, query, compare data
    logic [15:0] exp;
  } hfc_row_t;

  localparam logic [15:0] ID_WORD = 16'h3C4B; // Arbitrary value
  localparam logic [359:0] QRY_TBL = {128'h51525902004000000000002736000003,
    136'h04090005050400190200060001FF000002, 96'h0};
  logic sys_clk, rst, byteMode, reqValid, reqReady, rspValid, rspErr;
  logic rspMatch, secureActive, queryActive, flashResetN;
  logic [15:0] rspData, dqIn, modelDq, got, expW;
  hfc_req_t req;
  hfc_pins_t pins;
  int failCount = 0, samplesChecked = 0, cycles = 0, lowCycles = 0, n0;
  hfc_row_t rows [30] = '{
    '{OP_SEC_EXIT, 25'h0, 16'h0, 4'h8, 16'h0},
    '{OP_QRY_EXIT, 25'h0, 16'h0, 4'h8, 16'h0},
    '{OP_SEC_ENTER, 25'h0, 16'h0, 4'h4, 16'h0},
    '{OP_SEC_ENTER, 25'h0, 16'h0, 4'hC, 16'h0},
    '{OP_READ, 25'h0, 16'h0, 4'h5, 16'h5E00},
    '{OP_READ, 25'h7F, 16'h0, 4'h5, 16'h5E7F},
    '{OP_READ, 25'h10000, 16'h0, 4'h5, 16'hA5C3},
    '{OP_WRITE, 25'h555, 16'hAA, 4'h4, 16'h0},
    '{OP_WRITE, 25'h2AA, 16'h55, 4'h4, 16'h0},
    '{OP_WRITE, 25'h555, 16'hA0, 4'h4, 16'h0},
    '{OP_WRITE, 25'h8, 16'h1234, 4'h4, 16'h0},
    '{OP_READ, 25'h8, 16'h0, 4'h5, 16'h1234},
    '{OP_QRY_ENTER, 25'h0, 16'h0, 4'h6, 16'h0},
    '{OP_SEC_EXIT, 25'h0, 16'h0, 4'hE, 16'h0},
    '{OP_QRY_ENTER, 25'h0, 16'h0, 4'hE, 16'h0},
    '{OP_READ, 25'h10, 16'h0, 4'h7, 16'h0051},
    '{OP_QRY_EXIT, 25'h0, 16'h0, 4'h4, 16'h0},
    '{OP_READ, 25'h8, 16'h0, 4'h5, 16'h1234},
    '{OP_SEC_EXIT, 25'h0, 16'h0, 4'h0, 16'h0},
    '{OP_READ, 25'h8, 16'h0, 4'h1, 16'hA5CB},
    '{OP_WRITE, 25'h555, 16'hAA, 4'h0, 16'h0},
    '{OP_WRITE, 25'h2AA, 16'h55, 4'h0, 16'h0},
    '{OP_WRITE, 25'h555, 16'h90, 4'h0, 16'h0},
    '{OP_QRY_ENTER, 25'h0, 16'h0, 4'h2, 16'h0},
    '{OP_READ, 25'h11, 16'h0, 4'h3, 16'h0052},
    '{OP_QRY_EXIT, 25'h0, 16'h0, 4'h0, 16'h0},
    '{OP_READ, 25'h0, 16'h0, 4'h1, ID_WORD},
    '{OP_WRITE, 25'h0, 16'hF0, 4'h0, 16'h0},
    '{OP_READ, 25'h0, 16'h0, 4'h1, 16'hA5C3},
    '{OP_PROBE, 25'h0, 16'h0, 4'h1, 16'h0012}};

  // Bus wire: whoever enables a bit owns it
  assign dqIn = (pins.dqOut & pins.dqOe) | (modelDq & ~pins.dqOe);

  hfc_host hfc_host_i (.sys_clk(sys_clk), .rst(rst), .byteMode(byteMode),
    .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
    .rspMatch(rspMatch), .secureActive(secureActive),
    .queryActive(queryActive), .pins(pins), .flashResetN(flashResetN),
    .dqIn(dqIn));

  hfc_flash_model #(.ID_WORD(ID_WORD)) hfc_flash_model_i (
    .byteMode(byteMode), .pins(pins), .flashResetN(flashResetN),
    .dqBus(dqIn), .dqDrive(modelDq));

  always #12.5 sys_clk = ~sys_clk;

  // Hang guard and hardware reset width meter
  always @(posedge sys_clk) begin
    cycles++;
    if (flashResetN === 1'h0) lowCycles++;
    if (cycles == 20000) begin
      failCount++;
      stopTest();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One request: hold until taken, then wait for the answer
  task automatic do_req(input hfc_op_t op, input logic [24:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{op, a, d};
    reqValid <= 1'h1;
    do @(posedge sys_clk); while (reqReady !== 1'h1 && ++n < 50);
    reqValid <= 1'h0;
    if (n >= 50) failCount++; // Never taken: counts as a mismatch
    n = 0;
    // A refusal answers right after the take edge, so look before waiting
    #1;
    while (rspValid !== 1'h1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (rspValid !== 1'h1) failCount++; // No answer in time
  endtask : do_req

  task automatic stopTest();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stopTest

  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    byteMode = 1'h0;
    reqValid = 1'h0;
    req = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    got = 16'({reqReady, pins.ceN, pins.oeN, pins.weN, flashResetN});
    check(got, 16'h1F);
    check(16'({secureActive, queryActive, rspMatch}), 16'h0);
    // Scripted rows; the last probe meets the array, not the table
    foreach (rows[i]) begin
      do_req(rows[i].op, rows[i].addr, rows[i].data);
      got = 16'({rspErr, secureActive, queryActive});
      check(got, 16'(rows[i].flags[3:1]));
      if (rows[i].op == OP_PROBE) check(16'(rspMatch), 16'h0);
      else if (rows[i].flags[0]) check(rspData, rows[i].exp);
    end
    // Whole table with stray upper address bits set
    do_req(OP_QRY_ENTER, 25'h0, 16'h0);
    for (int i = 0; i < 45; i++) begin
      do_req(OP_READ, 25'h0ABCD80 | 25'(16 + i), 16'h0);
      expW = {8'h00, QRY_TBL[359 - 8 * i -: 8]};
      if (i < 11) check(rspData, expW);
      else if (i < 23) check(rspData, expW);
      else check(rspData, expW);
    end
    do_req(OP_PROBE, 25'h0, 16'h0);
    check(16'(rspMatch), 16'h1);
    do_req(OP_QRY_EXIT, 25'h0, 16'h0);
    // Byte mode: doubled addresses, value on the low lane
    @(posedge sys_clk);
    byteMode <= 1'h1;
    do_req(OP_QRY_ENTER, 25'h0, 16'h0);
    check(16'(queryActive), 16'h1);
    do_req(OP_READ, 25'h20, 16'h0);
    check(rspData, 16'h0051);
    do_req(OP_READ, 25'h21, 16'h0);
    check(rspData, 16'h0000);
    do_req(OP_READ, 25'h5A, 16'h0);
    check(rspData, 16'h00FF);
    do_req(OP_PROBE, 25'h0, 16'h0);
    check(16'(rspMatch), 16'h1);
    do_req(OP_QRY_EXIT, 25'h0, 16'h0);
    @(posedge sys_clk);
    byteMode <= 1'h0;
    // Hardware reset out of secure and query together
    do_req(OP_SEC_ENTER, 25'h0, 16'h0);
    check(16'(hfc_flash_model_i.accelAllowed), 16'h0);
    do_req(OP_QRY_ENTER, 25'h0, 16'h0);
    n0 = lowCycles;
    do_req(OP_HW_RESET, 25'h0, 16'h0);
    check(16'(lowCycles - n0), 16'(`HFC_RP_CYC));
    check(16'({rspErr, secureActive, queryActive}), 16'h0);
    check(16'(hfc_flash_model_i.accelAllowed), 16'h1);
    do_req(OP_READ, 25'h0, 16'h0);
    check(rspData, 16'hA5C3);
    stopTest();
  end
endmodule : hfc_host_test

//--- hfc_pkg.sv
// Purpose: Types shared by the host flash controller modules
// Assumes: hfc_defs.svh holds the numbers
// Notes: Device addresses are 25 bits: A23..A0 plus byte-lane bit
package hfc_pkg;

  // Operations the user can request
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_SEC_ENTER,
    OP_SEC_EXIT,
    OP_QRY_ENTER,
    OP_QRY_EXIT,
    OP_PROBE,
    OP_HW_RESET
  } hfc_op_t;

  // One user request
  typedef struct packed {
    hfc_op_t op;
    logic [24:0] addr;
    logic [15:0] data;
  } hfc_req_t;

  // One flash bus cycle
  typedef struct packed {
    logic isWrite;
    logic [24:0] addr;
    logic [15:0] data;
  } hfc_cyc_t;

  // Flash pins driven by the host (DQ15 doubles as A-1 in byte mode)
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dqOut;
    logic [15:0] dqOe;
    logic ceN;
    logic oeN;
    logic weN;
  } hfc_pins_t;

endpackage : hfc_pkg
